// ### shared/eeprom_ctrl_consts.svh
`ifndef EEPROM_CTRL_CONSTS_SVH
`define EEPROM_CTRL_CONSTS_SVH
// Register offsets on the plain register port
`define OFS_ADDR      3'h0
`define OFS_DATA      3'h1
`define OFS_CTRL      3'h2
`define OFS_KEY       3'h3
`define OFS_IRQ       3'h4
`define OFS_EXTCTL    3'h5
// Control register field positions
`define BIT_PGM_SEL   7
`define BIT_CFG_SEL   6
`define BIT_ROW_ERASE 4
`define BIT_FAULT     3
`define BIT_UPD_EN    2
`define BIT_LAUNCH    1
`define BIT_RD_START  0
// Flag register field position
`define BIT_DONE      4
// Unlock keys
`define KEY_FIRST     8'h55
`define KEY_SECOND    8'hAA
// Timing
`define CLK_HZ        10_000_000
`define PWRT_MS       72
`define PWRT_CYCLES   ((`PWRT_MS * `CLK_HZ) / 1000)
`define WRITE_CYCLES  40000
`endif

// ### shared/eeprom_ctrl_pkg.sv
`default_nettype none
package eeprom_ctrl_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_ARMED} unlock_t;
    typedef enum logic [1:0] {W_IDLE, W_BUSY} wstate_t;
endpackage
`default_nettype wire

// ### shared/eeprom_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eeprom_mem_if;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### core/eeprom_array.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_array
(
    input  wire logic   i_clk,
    eeprom_mem_if.mem   mif
);
    logic [7:0] cells [0:255];

    // Erase-before-write collapses to a plain overwrite at commit time
    always_ff @(posedge i_clk)
    begin
        if (mif.we)
            cells[mif.addr] <= mif.wdata;
    end

    // Combinational read so a read lands within one cycle
    assign mif.rdata = cells[mif.addr];
endmodule // eeprom_array
`default_nettype wire

// ### core/data_eeprom_access_ctrl.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_consts.svh"
module data_eeprom_access_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int WRITE_CYCLES = `WRITE_CYCLES,
    parameter int PWRT_CYCLES  = `PWRT_CYCLES
)
(
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST,
    input  wire logic       i_POR,
    input  wire logic       i_ABORT_RST,
    input  wire logic       i_CODE_PROTECT,
    input  wire logic       i_EXTERNAL,
    input  wire logic [2:0] i_ADDR,
    input  wire logic [7:0] i_WDATA,
    input  wire logic       i_WR,
    input  wire logic       i_RD,
    output logic      [7:0] o_RDATA,
    output logic            o_BUSY,
    output logic            o_DONE_IRQ_FLAG
);
    logic [7:0] eeprom_address_reg_r;
    logic [7:0] eeprom_data_reg_r;
    logic       pgm_sel_r, cfg_sel_r, row_erase_r, fault_r;
    logic       upd_en_r, launch_r, done_r;
    logic [7:0] rdata_r;
    unlock_t    unlock_r, unlock_nxt;
    wstate_t    wst_r;
    logic [15:0] wcnt_r;
    logic [19:0] pwrt_r;
    logic       por_s1, por_s2, ab_s1, ab_s2, cp_s1, cp_s2, ex_s1, ex_s2;

    eeprom_mem_if mif();

    eeprom_array u_array
    (
        .i_clk (I_SYS_CLK),
        .mif   (mif)
    );

    // Pin inputs pass two flops before use
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            {por_s1, por_s2, ab_s1, ab_s2} <= 4'h0;
            {cp_s1, cp_s2, ex_s1, ex_s2}   <= 4'h0;
        end
        else
        begin
            por_s1 <= i_POR;          por_s2 <= por_s1;
            ab_s1  <= i_ABORT_RST;    ab_s2  <= ab_s1;
            cp_s1  <= i_CODE_PROTECT; cp_s2  <= cp_s1;
            ex_s1  <= i_EXTERNAL;     ex_s2  <= ex_s1;
        end
    end

    // Decode of register port; external master is locked out under protect
    wire blocked   = cp_s2 & ex_s2;
    wire wr_ok     = i_WR & ~blocked;
    wire rd_ok     = i_RD & ~blocked;
    wire wr_addr   = wr_ok & (i_ADDR == `OFS_ADDR);
    wire wr_data   = wr_ok & (i_ADDR == `OFS_DATA);
    wire wr_ctrl   = wr_ok & (i_ADDR == `OFS_CTRL);
    wire wr_key    = wr_ok & (i_ADDR == `OFS_KEY);
    wire wr_irq    = wr_ok & (i_ADDR == `OFS_IRQ);
    wire pwrt_busy = (pwrt_r != 20'h0_0000);
    wire writing   = (wst_r == W_BUSY);
    wire abort     = ab_s2 & writing;
    wire wdone     = writing & (wcnt_r == 16'h0000);
    // Launch: armed, enable already set, not powering up, data space only
    wire launch_go = wr_ctrl & i_WDATA[`BIT_LAUNCH] & upd_en_r
                     & (unlock_r == ST_ARMED) & ~pwrt_busy & ~writing
                     & ~i_WDATA[`BIT_PGM_SEL] & ~i_WDATA[`BIT_CFG_SEL];
    // Read start refused while program space selected
    wire read_go   = wr_ctrl & i_WDATA[`BIT_RD_START] & ~i_WDATA[`BIT_PGM_SEL]
                     & ~i_WDATA[`BIT_CFG_SEL];

    assign mif.addr  = eeprom_address_reg_r;
    assign mif.wdata = eeprom_data_reg_r;
    assign mif.we    = wdone & ~ab_s2;

    // Unlock: any access other than the exact next step disarms
    always_comb
    begin
        unlock_nxt = ST_IDLE;
        if (wr_key && i_WDATA == `KEY_FIRST)
            unlock_nxt = ST_KEY1;
        else if (unlock_r == ST_KEY1 && wr_key && i_WDATA == `KEY_SECOND)
            unlock_nxt = ST_ARMED;
    end

    // Control/state registers
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            eeprom_address_reg_r <= 8'h00;
            eeprom_data_reg_r    <= 8'h00;
            {pgm_sel_r, cfg_sel_r, row_erase_r, fault_r} <= 4'h0;
            {upd_en_r, launch_r, done_r} <= 3'h0;
            unlock_r <= ST_IDLE;
            wst_r    <= W_IDLE;
            wcnt_r   <= 16'h0000;
            pwrt_r   <= 20'h0_0000;
        end
        else
        begin
            unlock_r <= (i_WR | i_RD) ? unlock_nxt : unlock_r;
            if (por_s2)
            begin
                upd_en_r <= 1'b0;
                pwrt_r   <= 20'(PWRT_CYCLES);
            end
            else if (pwrt_busy)
                pwrt_r <= pwrt_r - 20'h0_0001;
            if (abort)
            begin
                fault_r              <= 1'b1;
                eeprom_address_reg_r <= 8'h00;
                eeprom_data_reg_r    <= 8'h00;
                launch_r             <= 1'b0;
                wst_r                <= W_IDLE;
            end
            else
            begin
                if (wr_addr) eeprom_address_reg_r <= i_WDATA;
                if (wr_data) eeprom_data_reg_r    <= i_WDATA;
                else if (read_go) eeprom_data_reg_r <= mif.rdata;
                if (wr_ctrl)
                begin
                    pgm_sel_r <= i_WDATA[`BIT_PGM_SEL];
                    cfg_sel_r <= i_WDATA[`BIT_CFG_SEL];
                    upd_en_r  <= i_WDATA[`BIT_UPD_EN] & ~por_s2;
                    fault_r   <= i_WDATA[`BIT_FAULT];
                    row_erase_r <= launch_go ? 1'b0 : i_WDATA[`BIT_ROW_ERASE];
                end
                if (launch_go)
                begin
                    launch_r <= 1'b1;
                    fault_r  <= 1'b0;
                    wst_r    <= W_BUSY;
                    wcnt_r   <= 16'(WRITE_CYCLES - 1);
                end
                else if (wdone)
                begin
                    launch_r <= 1'b0;
                    wst_r    <= W_IDLE;
                end
                else if (writing)
                    wcnt_r <= wcnt_r - 16'h0001;
            end
            // Set beats a simultaneous software clear
            if (wdone & ~ab_s2)
                done_r <= 1'b1;
            else if (wr_irq & ~i_WDATA[`BIT_DONE])
                done_r <= 1'b0;
        end
    end

    // Read mux; key port has no storage, read start always reads zero
    wire [7:0] ctrl_view = {pgm_sel_r, cfg_sel_r, 1'b0, row_erase_r,
                            fault_r, upd_en_r, launch_r, 1'b0};
    logic [7:0] rmux;
    always_comb
    begin
        case (i_ADDR)
            `OFS_ADDR: rmux = eeprom_address_reg_r;
            `OFS_DATA: rmux = eeprom_data_reg_r;
            `OFS_CTRL: rmux = ctrl_view;
            `OFS_KEY:  rmux = 8'h00;
            `OFS_IRQ:  rmux = {3'h0, done_r, 4'h0};
            default:   rmux = 8'h00;
        endcase
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
            rdata_r <= 8'h00;
        else
            rdata_r <= rd_ok ? rmux : 8'h00;
    end

    assign o_RDATA         = rdata_r;
    assign o_BUSY          = launch_r;
    assign o_DONE_IRQ_FLAG = done_r;

    property p_launch_needs_arm;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        $rose(launch_r) |-> $past(unlock_r) == ST_ARMED && $past(upd_en_r);
    endproperty
    a_launch_needs_arm: assert property (p_launch_needs_arm) else $error("bad launch");

    property p_no_write_pwrt;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        pwrt_busy |=> !$rose(launch_r);
    endproperty
    a_no_write_pwrt: assert property (p_no_write_pwrt) else $error("write in pwrt");

    property p_done_sets;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (wdone && !ab_s2) |=> done_r && !launch_r;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done not set");

    property p_abort;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        abort |=> fault_r && eeprom_address_reg_r == 8'h00 && eeprom_data_reg_r == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort state");

    property p_read_next;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (read_go && !wr_data && !abort) |=> eeprom_data_reg_r == $past(mif.rdata);
    endproperty
    a_read_next: assert property (p_read_next) else $error("read late");

    property p_hold;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (!read_go && !wr_data && !abort) |=> $stable(eeprom_data_reg_r);
    endproperty
    a_hold: assert property (p_hold) else $error("data changed");

    property p_key_read;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (rd_ok && i_ADDR == `OFS_KEY) |=> o_RDATA == 8'h00;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key reads nonzero");

    property p_busy_len;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        $rose(launch_r) |-> launch_r [*2];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("short write");

    // Unlock steps on consecutive strobes; a clean launch must not be lost
    sequence s_key_first;
        wr_key && i_WDATA == `KEY_FIRST;
    endsequence

    sequence s_key_second;
        wr_key && i_WDATA == `KEY_SECOND;
    endsequence

    sequence s_launch_req;
        wr_ctrl && i_WDATA[`BIT_LAUNCH] && upd_en_r && !pwrt_busy && !writing
            && !i_WDATA[`BIT_PGM_SEL] && !i_WDATA[`BIT_CFG_SEL];
    endsequence

    property p_unlock_launch;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        s_key_first ##1 s_key_second ##1 s_launch_req |=> launch_r;
    endproperty
    a_unlock_launch: assert property (p_unlock_launch) else $error("launch lost");
endmodule // data_eeprom_access_ctrl
`default_nettype wire

// ### dv/tb_data_eeprom_access_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_ctrl_consts.svh"
module tb_data_eeprom_access_ctrl;
    localparam int WC = 10;
    localparam int PC = 20;
    logic       sys_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       por       = 1'b0;
    logic       abort_rst = 1'b0;
    logic       protect   = 1'b0;
    logic       ext       = 1'b0;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic [2:0] addr      = 3'h0;
    logic [7:0] wdata     = 8'h00;
    logic [7:0] rdata;
    logic       busy;
    logic       done_flag;
    logic [7:0] rv;
    int         err_count = 0;
    int         n_tests   = 0;
    int         n;

    data_eeprom_access_ctrl #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PC)) dut_u
    (
        .I_SYS_CLK       (sys_clk),
        .I_RST           (rst),
        .i_POR           (por),
        .i_ABORT_RST     (abort_rst),
        .i_CODE_PROTECT  (protect),
        .i_EXTERNAL      (ext),
        .i_ADDR          (addr),
        .i_WDATA         (wdata),
        .i_WR            (wr),
        .i_RD            (rd),
        .o_RDATA         (rdata),
        .o_BUSY          (busy),
        .o_DONE_IRQ_FLAG (done_flag)
    );

    // Free-running 10 MHz clock
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; every signal set once per step, so strobes may run back to back
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic put(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic get(input logic [2:0] a, output logic [7:0] v);
        bus(1'b0, 1'b1, a, 8'h00);
        v = rdata;
    endtask

    task automatic idle(input int cycles);
        repeat (cycles) bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask

    // Key pair then launch, with no other access in between
    task automatic launch();
        put(`OFS_KEY, `KEY_FIRST);
        put(`OFS_KEY, `KEY_SECOND);
        put(`OFS_CTRL, 8'h06);
        idle(1);
    endtask

    // Bounded wait on the self-timed write; counts busy cycles
    task automatic wait_write(output int cnt);
        cnt = 0;
        while (busy === 1'b1 && cnt < 200)
        begin
            idle(1);
            cnt++;
        end
        if (cnt >= 200)
        begin
            err_count++;
            test_done();
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst <= 1'b0;
        idle(1);
        get(`OFS_CTRL, rv);
        chk(rv & 8'h07, 8'h00);
        chk({6'h00, busy, done_flag}, 8'h00);
        put(`OFS_KEY, `KEY_FIRST);
        get(`OFS_KEY, rv);
        chk(rv, 8'h00);
        $display("test reset done");

        // Power-up clears the enable and holds writes off while the timer runs
        put(`OFS_CTRL, 8'h04);
        por <= 1'b1;
        idle(3);
        por <= 1'b0;
        idle(3);
        get(`OFS_CTRL, rv);
        chk(rv & 8'h04, 8'h00);
        put(`OFS_CTRL, 8'h04);
        launch();
        chk({7'h00, busy}, 8'h00);
        idle(PC + 5);
        $display("test power_up done");

        // Enable in the launching write itself, then a broken key sequence
        put(`OFS_CTRL, 8'h00);
        launch();
        chk({7'h00, busy}, 8'h00);
        put(`OFS_CTRL, 8'h04);
        put(`OFS_KEY, `KEY_FIRST);
        get(`OFS_ADDR, rv);
        put(`OFS_KEY, `KEY_SECOND);
        put(`OFS_CTRL, 8'h06);
        idle(1);
        chk({7'h00, busy}, 8'h00);
        $display("test refused_launch done");

        // Good write; clearing enable and launch mid-cycle must not stop it
        put(`OFS_ADDR, 8'hFF);
        put(`OFS_DATA, 8'hA5);
        launch();
        chk({7'h00, busy}, 8'h01);
        put(`OFS_CTRL, 8'h00);
        chk({7'h00, busy}, 8'h01);
        wait_write(n);
        // Wait starts two cycles into the write, so WC - 2 busy polls remain
        chk(8'(n), 8'(WC - 2));
        chk({7'h00, done_flag}, 8'h01);
        idle(3);
        chk({7'h00, done_flag}, 8'h01);
        put(`OFS_IRQ, 8'h00);
        idle(1);
        chk({7'h00, done_flag}, 8'h00);
        put(`OFS_ADDR, 8'h00);
        put(`OFS_DATA, 8'h3C);
        put(`OFS_CTRL, 8'h04);
        launch();
        wait_write(n);
        get(`OFS_CTRL, rv);
        chk(rv & 8'h0E, 8'h04);
        $display("test write done");

        // Reads at both ends of the array, hold, and refused selects
        put(`OFS_ADDR, 8'hFF);
        put(`OFS_CTRL, 8'h01);
        get(`OFS_DATA, rv);
        chk(rv, 8'hA5);
        put(`OFS_ADDR, 8'h00);
        put(`OFS_CTRL, 8'h01);
        get(`OFS_DATA, rv);
        chk(rv, 8'h3C);
        put(`OFS_ADDR, 8'hFF);
        idle(3);
        get(`OFS_DATA, rv);
        chk(rv, 8'h3C);
        for (int i = 0; i < 2; i++)
        begin
            put(`OFS_CTRL, (8'h80 >> i) | 8'h01);
            get(`OFS_DATA, rv);
            chk(rv, 8'h3C);
        end
        put(`OFS_CTRL, 8'h00);
        $display("test read done");

        // Protected external access is ignored, internal access is not
        protect <= 1'b1;
        ext     <= 1'b1;
        idle(3);
        put(`OFS_ADDR, 8'h12);
        ext     <= 1'b0;
        idle(3);
        get(`OFS_ADDR, rv);
        chk(rv, 8'hFF);
        put(`OFS_ADDR, 8'h12);
        get(`OFS_ADDR, rv);
        chk(rv, 8'h12);
        protect <= 1'b0;
        $display("test protect done");

        // Reset in mid-write flags the fault and zeroes address and data
        put(`OFS_DATA, 8'h77);
        put(`OFS_CTRL, 8'h04);
        launch();
        idle(2);
        abort_rst <= 1'b1;
        idle(3);
        abort_rst <= 1'b0;
        idle(4);
        chk({7'h00, busy}, 8'h00);
        get(`OFS_CTRL, rv);
        chk(rv & 8'h08, 8'h08);
        get(`OFS_ADDR, rv);
        chk(rv, 8'h00);
        get(`OFS_DATA, rv);
        chk(rv, 8'h00);
        $display("test abort done");
        test_done();
    end
endmodule // tb_data_eeprom_access_ctrl
`default_nettype wire
